//--- pkg/pdm_pkg.sv
// Constants, types and helpers of the device-memory command interpreter
package pdm_pkg;
    // Command codes
    localparam logic [15:0] CMD_BATCH_RD = 16'h0401;
    localparam logic [15:0] CMD_BATCH_WR = 16'h1401;
    localparam logic [15:0] CMD_RAND_RD  = 16'h0403;
    localparam logic [15:0] CMD_MON_REG  = 16'h0802;

    // Point-count limits
    localparam logic [15:0] LIM_BIT_PRI    = 16'd3952;
    localparam logic [15:0] LIM_BIT_RD_OTH = 16'd256;
    localparam logic [15:0] LIM_BIT_WR_OTH = 16'd160;
    localparam logic [15:0] LIM_WRD_PRI    = 16'd480;
    localparam logic [15:0] LIM_BW_RD_OTH  = 16'd32;
    localparam logic [15:0] LIM_BW_WR_OTH  = 16'd10;
    localparam logic [15:0] LIM_WW_OTH     = 16'd64;
    localparam int          BIT_WORD_SHIFT = 4;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CMD    = 8'h04;
    localparam logic [7:0] ADDR_HEAD   = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0c;
    localparam logic [7:0] ADDR_RCOUNT = 8'h10;
    localparam logic [7:0] ADDR_MAXDEV = 8'h14;
    localparam logic [7:0] ADDR_COND   = 8'h18;
    localparam logic [7:0] ADDR_CMPV   = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // Field positions
    localparam int CTRL_GO_BIT     = 0;
    localparam int CTRL_ASCII_BIT  = 1;
    localparam int CTRL_PRI_BIT    = 2;
    localparam int CTRL_BITDEV_BIT = 3;
    localparam int SUB_WORD_BIT    = 0;
    localparam int SUB_COND_BIT    = 6;
    localparam int COND_BIT_EN     = 0;
    localparam int COND_BIT_LVL    = 1;
    localparam int COND_WORD_EN    = 2;
    localparam int COND_STEP_EN    = 3;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_NAK_BIT    = 2;
    localparam int STAT_CAUSE_LSB  = 4;
    localparam int STAT_PROT_BIT   = 8;
    localparam int STAT_OMON_BIT   = 9;

    // Reset value of every register
    localparam logic [31:0] REG_RST = 32'h0;

    typedef enum logic [3:0] {
        CAUSE_NONE    = 4'h0,
        CAUSE_CMD     = 4'h1,
        CAUSE_COUNT   = 4'h2,
        CAUSE_RANGE   = 4'h3,
        CAUSE_ALIGN   = 4'h4,
        CAUSE_PROTECT = 4'h5,
        CAUSE_MONBUSY = 4'h6,
        CAUSE_SUBCMD  = 4'h7
    } pdm_cause_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_REQ   = 2'b11,
        ST_SCAN  = 2'b10
    } pdm_state_e;

    // One ASCII hex character to a nibble
    function automatic logic [3:0] hex_nib(input logic [7:0] ch);
        if (ch >= 8'h61)
            return 4'(ch - 8'h57);
        else if (ch >= 8'h41)
            return 4'(ch - 8'h37);
        else
            return ch[3:0];
    endfunction

    // Point count field: two ASCII digits (high first) or one byte
    function automatic logic [7:0] pt_count(input logic [15:0] raw, input logic ascii);
        if (ascii)
            return {hex_nib(raw[15:8]), hex_nib(raw[7:0])};
        else
            return raw[7:0];
    endfunction
endpackage

//--- pkg/pdm_chk_if.sv
// Request-to-limit-checker carrier
`timescale 1ns/10ps
interface pdm_chk_if;
    import pdm_pkg::*;
    logic       is_wr;
    logic       is_rand;
    logic       word_unit;
    logic       bit_dev;
    logic       primary;
    logic [23:0] head;
    logic [15:0] count;
    logic [23:0] max_dev;
    pdm_cause_e  cause;

    modport req (output is_wr, is_rand, word_unit, bit_dev, primary, head, count, max_dev,
                 input cause);
    modport chk (input is_wr, is_rand, word_unit, bit_dev, primary, head, count, max_dev,
                 output cause);
endinterface

//--- src/pdm_limit_check.sv
// Point-count, alignment and range checker for one request
`timescale 1ns/10ps
module pdm_limit_check import pdm_pkg::*; #(
    parameter logic [15:0] RND_MAX_PTS = 16'd192
) (
    pdm_chk_if.chk c
);
    logic [15:0] lim;
    logic [19:0] span;
    logic [25:0] last;

    // Limit by family, unit, device kind and direction
    always_comb begin
        if (c.is_rand)
            lim = RND_MAX_PTS;
        else if (!c.word_unit)
            lim = c.primary ? LIM_BIT_PRI : (c.is_wr ? LIM_BIT_WR_OTH : LIM_BIT_RD_OTH); // see RL2 RL5
        else if (c.bit_dev)
            lim = c.primary ? LIM_WRD_PRI : (c.is_wr ? LIM_BW_WR_OTH : LIM_BW_RD_OTH); // see RL3 RL6
        else
            lim = c.primary ? LIM_WRD_PRI : LIM_WW_OTH; // see RL4
    end

    // Last device touched; bit devices in words cover 16 each
    always_comb begin
        span = (c.word_unit && c.bit_dev) ? {c.count, 4'h0} : {4'h0, c.count}; // see RL7
        last = 26'(c.head) + 26'(span) - 26'd1;
    end

    // First failing check wins
    always_comb begin
        c.cause = CAUSE_NONE;
        if (c.count == 16'h0 || c.count > lim)
            c.cause = CAUSE_COUNT; // see RL21
        else if (!c.is_rand && !c.primary && c.word_unit && c.bit_dev
                 && c.head[BIT_WORD_SHIFT-1:0] != '0)
            c.cause = CAUSE_ALIGN; // see RL8
        else if (!c.is_rand && last > 26'(c.max_dev))
            c.cause = CAUSE_RANGE; // see RL7
    end
endmodule

//--- src/pdm_cmd_top.sv
// Device-memory command interpreter with APB registers and CPU handshake
//
// Summary of operation
// RL1 - Decode 0401 read, 1401 write, 0403 random
// RL2 - Bit read: 1..3952 primary, else 1..256
// RL3 - Word read of bits: 1..480 or 1..32
// RL4 - Word read of words, other CPU: 1..64
// RL5 - Bit write: 1..3952 primary, else 1..160
// RL6 - Word write of bits: 1..480 or 1..10
// RL7 - Last device must not pass maximum
// RL8 - Other CPU, bits in words: head multiple 16
// RL9 - Protected primary CPU write answers NAK
// RL10 - Random read in 16/32-bit, 1/2-word units
// RL11 - Condition: bit device on or off
// RL12 - Condition: masked word value reached
// RL13 - Condition: program step executed
// RL14 - Several conditions may be combined
// RL15 - Unconditional: sample at first end-scan
// RL16 - Conditional: first end-scan meeting condition
// RL17 - Other conditional monitor present: NAK
// RL18 - Other unconditional monitor: still accept
// RL19 - No condition: subcommand must be 0000
// RL20 - Point count: two ASCII digits or byte
// RL21 - Bad count or range: NAK, no access
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module pdm_cmd_top import pdm_pkg::*; #(
    parameter logic [15:0] RND_MAX_PTS = 16'd192
) (
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        system_protect_switch_i,
    input  wire logic        other_cond_mon_i,
    input  wire logic        cpu_ack_i,
    input  wire logic        cpu_end_scan_i,
    input  wire logic        cpu_cond_bit_i,
    input  wire logic        cpu_step_hit_i,
    input  wire logic [15:0] cpu_word_val_i,
    output logic             cpu_req_o,
    output logic             cpu_wr_o,
    output logic             cpu_cond_o,
    output logic             cpu_sample_o,
    output logic             rsp_ack_o,
    output logic             rsp_nak_o
);
    localparam int SW = 22;

    logic [SW-1:0] sync_a;
    logic [SW-1:0] sync_b;
    logic          end_dly;
    logic          s_protect;
    logic          s_other;
    logic          s_ack;
    logic          s_end;
    logic          s_bit;
    logic          s_step;
    logic [15:0]   s_word;
    logic          end_rise;

    // Pins pass two flops before use
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_a  <= '0;
            sync_b  <= '0;
            end_dly <= 1'b0;
        end else begin
            sync_a  <= {cpu_word_val_i, cpu_step_hit_i, cpu_cond_bit_i,
                        cpu_end_scan_i, cpu_ack_i, other_cond_mon_i,
                        system_protect_switch_i};
            sync_b  <= sync_a;
            end_dly <= sync_b[3];
        end
    end

    // Named views of the synchronised pins
    assign s_protect = sync_b[0];
    assign s_other   = sync_b[1];
    assign s_ack     = sync_b[2];
    assign s_end     = sync_b[3];
    assign s_bit     = sync_b[4];
    assign s_step    = sync_b[5];
    assign s_word    = sync_b[SW-1:6];
    assign end_rise  = s_end && !end_dly;

    // Software-visible request registers
    logic [3:1]  ctrl;
    logic [15:0] cmd_code;
    logic [15:0] sub_code;
    logic [23:0] head;
    logic [15:0] count;
    logic [31:0] rcount;
    logic [23:0] max_dev;
    logic [3:0]  cond;
    logic [31:0] cmpv;
    logic [3:1]  next_ctrl;
    logic [15:0] next_cmd_code;
    logic [15:0] next_sub_code;
    logic [23:0] next_head;
    logic [15:0] next_count;
    logic [31:0] next_rcount;
    logic [23:0] next_max_dev;
    logic [3:0]  next_cond;
    logic [31:0] next_cmpv;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        acc;
    logic        wr_acc;
    logic        go;
    logic        clr_done;
    logic        clr_nak;
    logic        hit;
    logic [31:0] rd_val;

    // FSM state declared early for the status read
    pdm_state_e  state;
    pdm_cause_e  cause;
    logic        done;
    logic        nak;

    // One wait state: access completes on the edge with pready high
    assign acc      = psel_i && penable_i && pready_o;
    assign wr_acc   = acc && pwrite_i;
    assign go       = wr_acc && paddr_i == ADDR_CTRL && pwdata_i[CTRL_GO_BIT]
                      && state == ST_IDLE;
    assign clr_done = wr_acc && paddr_i == ADDR_STATUS && pwdata_i[STAT_DONE_BIT];
    assign clr_nak  = wr_acc && paddr_i == ADDR_STATUS && pwdata_i[STAT_NAK_BIT];

    // Read mux and address decode
    always_comb begin
        hit    = 1'b1;
        rd_val = REG_RST;
        unique case (paddr_i)
            ADDR_CTRL:   rd_val[3:1] = ctrl;
            ADDR_CMD:    rd_val = {sub_code, cmd_code};
            ADDR_HEAD:   rd_val[23:0] = head;
            ADDR_COUNT:  rd_val[15:0] = count;
            ADDR_RCOUNT: rd_val = rcount;
            ADDR_MAXDEV: rd_val[23:0] = max_dev;
            ADDR_COND:   rd_val[3:0] = cond;
            ADDR_CMPV:   rd_val = cmpv;
            ADDR_STATUS: begin
                rd_val[STAT_BUSY_BIT] = state != ST_IDLE;
                rd_val[STAT_DONE_BIT] = done;
                rd_val[STAT_NAK_BIT]  = nak;
                rd_val[STAT_CAUSE_LSB +: 4] = cause;
                rd_val[STAT_PROT_BIT] = s_protect;
                rd_val[STAT_OMON_BIT] = s_other;
            end
            default:     hit = 1'b0;
        endcase
    end

    // Register writes and APB answer
    always_comb begin
        next_ctrl     = ctrl;
        next_cmd_code = cmd_code;
        next_sub_code = sub_code;
        next_head     = head;
        next_count    = count;
        next_rcount   = rcount;
        next_max_dev  = max_dev;
        next_cond     = cond;
        next_cmpv     = cmpv;
        next_pready   = psel_i && penable_i && !pready_o;
        next_prdata   = (next_pready && !pwrite_i && hit) ? rd_val : REG_RST;
        next_pslverr  = next_pready && !hit;
        if (wr_acc && state == ST_IDLE) begin
            unique case (paddr_i)
                ADDR_CTRL:   next_ctrl     = pwdata_i[3:1];
                ADDR_CMD:    {next_sub_code, next_cmd_code} = pwdata_i;
                ADDR_HEAD:   next_head     = pwdata_i[23:0];
                ADDR_COUNT:  next_count    = pwdata_i[15:0];
                ADDR_RCOUNT: next_rcount   = pwdata_i;
                ADDR_MAXDEV: next_max_dev  = pwdata_i[23:0];
                ADDR_COND:   next_cond     = pwdata_i[3:0];
                ADDR_CMPV:   next_cmpv     = pwdata_i;
                default:     next_ctrl     = ctrl;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl      <= '0;
            cmd_code  <= '0;
            sub_code  <= '0;
            head      <= '0;
            count     <= '0;
            rcount    <= REG_RST;
            max_dev   <= '0;
            cond      <= '0;
            cmpv      <= REG_RST;
            prdata_o  <= REG_RST;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            ctrl      <= next_ctrl;
            cmd_code  <= next_cmd_code;
            sub_code  <= next_sub_code;
            head      <= next_head;
            count     <= next_count;
            rcount    <= next_rcount;
            max_dev   <= next_max_dev;
            cond      <= next_cond;
            cmpv      <= next_cmpv;
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // Command decode
    logic       is_rd;
    logic       is_wr;
    logic       is_rand;
    logic       is_mon;
    logic       known;
    logic       want_cond;
    logic [8:0] rnd_total;

    assign is_rd     = cmd_code == CMD_BATCH_RD; // see RL1
    assign is_wr     = cmd_code == CMD_BATCH_WR; // see RL1
    assign is_rand   = cmd_code == CMD_RAND_RD;  // see RL1
    assign is_mon    = is_rand || cmd_code == CMD_MON_REG;
    assign known     = is_rd || is_wr || is_mon;
    assign want_cond = is_mon && sub_code[SUB_COND_BIT];
    // Word and double-word counts, ASCII or binary
    assign rnd_total = 9'(pt_count(rcount[15:0], ctrl[CTRL_ASCII_BIT]))
                     + 9'(pt_count(rcount[31:16], ctrl[CTRL_ASCII_BIT])); // see RL20 RL10

    // Limit checker hookup
    pdm_chk_if chk ();
    assign chk.is_wr     = is_wr;
    assign chk.is_rand   = is_mon;
    assign chk.word_unit = sub_code[SUB_WORD_BIT];
    assign chk.bit_dev   = ctrl[CTRL_BITDEV_BIT];
    assign chk.primary   = ctrl[CTRL_PRI_BIT];
    assign chk.head      = head;
    assign chk.count     = is_mon ? 16'(rnd_total) : count;
    assign chk.max_dev   = max_dev;

    pdm_limit_check #(
        .RND_MAX_PTS (RND_MAX_PTS)
    ) u_limit (
        .c (chk)
    );

    // Combined monitoring condition, all enabled terms must hold
    logic cond_ok;
    assign cond_ok = (!cond[COND_BIT_EN] || s_bit == cond[COND_BIT_LVL]) // see RL11
        && (!cond[COND_WORD_EN] || ((s_word ^ cmpv[15:0]) & cmpv[31:16]) == 16'h0) // see RL12
        && (!cond[COND_STEP_EN] || s_step) // see RL13
        && cond != 4'h0; // see RL14

    // Refusal cause in priority order
    pdm_cause_e verdict;
    always_comb begin
        verdict = chk.cause;
        if (!known)
            verdict = CAUSE_CMD; // see RL1
        else if (is_mon && s_other)
            verdict = CAUSE_MONBUSY; // see RL17 RL18
        else if (is_wr && ctrl[CTRL_PRI_BIT] && s_protect)
            verdict = CAUSE_PROTECT; // see RL9
        else if (is_mon && !sub_code[SUB_COND_BIT] && sub_code != 16'h0)
            verdict = CAUSE_SUBCMD; // see RL19
        else if (want_cond && cond == 4'h0)
            verdict = CAUSE_SUBCMD;
    end

    // Sequencer next values
    pdm_state_e next_state;
    pdm_cause_e next_cause;
    logic next_done;
    logic next_nak;
    logic next_req;
    logic next_wr;
    logic next_cnd;
    logic next_sample;
    logic next_ack;
    logic next_rnak;

    always_comb begin
        next_state  = state;
        next_cause  = cause;
        next_done   = done && !clr_done;
        next_nak    = nak && !clr_nak;
        next_req    = cpu_req_o;
        next_wr     = cpu_wr_o;
        next_cnd    = cpu_cond_o;
        next_sample = 1'b0;
        next_ack    = 1'b0;
        next_rnak   = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (go)
                    next_state = ST_CHECK;
            end
            ST_CHECK: begin
                next_cause = verdict;
                if (verdict != CAUSE_NONE) begin
                    next_nak   = 1'b1; // see RL21
                    next_rnak  = 1'b1;
                    next_state = ST_IDLE;
                end else begin
                    next_req   = 1'b1;
                    next_wr    = is_wr;
                    next_cnd   = want_cond;
                    next_state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (s_ack) begin
                    next_req   = 1'b0;
                    next_state = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (end_rise && (!cpu_cond_o || cond_ok)) begin // see RL15 RL16
                    next_sample = 1'b1;
                    next_ack    = 1'b1;
                    next_done   = 1'b1;
                    next_cnd    = 1'b0;
                    next_wr     = 1'b0;
                    next_state  = ST_IDLE;
                end
            end
        endcase
    end

    // Sequencer flops
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state        <= ST_IDLE;
            cause        <= CAUSE_NONE;
            done         <= 1'b0;
            nak          <= 1'b0;
            cpu_req_o    <= 1'b0;
            cpu_wr_o     <= 1'b0;
            cpu_cond_o   <= 1'b0;
            cpu_sample_o <= 1'b0;
            rsp_ack_o    <= 1'b0;
            rsp_nak_o    <= 1'b0;
        end else begin
            state        <= next_state;
            cause        <= next_cause;
            done         <= next_done;
            nak          <= next_nak;
            cpu_req_o    <= next_req;
            cpu_wr_o     <= next_wr;
            cpu_cond_o   <= next_cnd;
            cpu_sample_o <= next_sample;
            rsp_ack_o    <= next_ack;
            rsp_nak_o    <= next_rnak;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_unknown_cmd: assert property (state == ST_CHECK && !known |=> rsp_nak_o) // see RL1
        else $error("unknown command not refused");
    a_protect_nak: assert property (state == ST_CHECK && known && !is_mon && is_wr
        && ctrl[CTRL_PRI_BIT] && s_protect |=> rsp_nak_o && !cpu_req_o) // see RL9
        else $error("protected write reached CPU");
    a_monbusy_nak: assert property (state == ST_CHECK && is_mon && s_other
        |=> rsp_nak_o && cause == CAUSE_MONBUSY) // see RL17
        else $error("monitor clash not refused");
    a_clean_go: assert property (state == ST_CHECK && verdict == CAUSE_NONE
        |=> cpu_req_o ##0 state == ST_REQ) // see RL18
        else $error("valid request not forwarded");
    a_limit_nak: assert property (state == ST_CHECK && known && chk.cause != CAUSE_NONE
        |=> rsp_nak_o && !cpu_req_o && nak) // see RL21
        else $error("out-of-limit request forwarded");
    a_sample_edge: assert property (cpu_sample_o |-> $past(end_rise)
        && $past(state) == ST_SCAN) // see RL15
        else $error("sample without end-scan");
    a_cond_gate: assert property (cpu_sample_o && $past(cpu_cond_o)
        |-> $past(cond_ok)) // see RL16
        else $error("conditional sample with condition false");
    a_first_scan: assert property (state == ST_SCAN && end_rise && !cpu_cond_o
        |=> cpu_sample_o && rsp_ack_o ##1 !cpu_sample_o) // see RL15
        else $error("unconditional sample missed first end-scan");
    a_wait_cond: assert property (state == ST_SCAN && cpu_cond_o && !cond_ok
        |=> !cpu_sample_o) // see RL11 RL12 RL13 RL14
        else $error("sample taken before condition met");
endmodule

//--- sim/pdm_cpu_model.sv
// Behavioural controller CPU at the far side of the request handshake
`timescale 1ns/10ps
module pdm_cpu_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic req_i,
    output logic      ack_o,
    output logic      end_scan_o
);
    logic [4:0] scan_cnt;
    logic [3:0] wait_cnt;
    logic       slow;

    // Free-running scan with a 4-cycle end-of-scan window; ack alternates prompt and slow
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            scan_cnt   <= 5'h00;
            wait_cnt   <= 4'h0;
            slow       <= 1'b0;
            ack_o      <= 1'b0;
            end_scan_o <= 1'b0;
        end else begin
            scan_cnt   <= scan_cnt + 5'h01;
            end_scan_o <= scan_cnt >= 5'h1c;
            if (req_i && !ack_o) begin
                wait_cnt <= wait_cnt + 4'h1;
                if (wait_cnt == (slow ? 4'hc : 4'h1))
                    ack_o <= 1'b1;
            end else if (!req_i && ack_o) begin
                ack_o    <= 1'b0;
                wait_cnt <= 4'h0;
                slow     <= !slow;
            end
        end
    end
endmodule

//--- sim/plc_device_memory_protocol_bench.sv
// Self-checking bench of the device-memory command interpreter
`timescale 1ns/10ps
module plc_device_memory_protocol_bench import pdm_pkg::*;;
    logic        core_clk_i = 0, sys_rst_i = 1, psel = 0, pen = 0, pwr = 0;
    logic        prot = 0, omon = 0, cbit = 0, step = 0, err;
    logic [7:0]  paddr = 0;
    logic [15:0] wval = 0;
    logic [31:0] pwdata = 0, rd, prdata, r, seed = 32'h016451bb;
    logic        pready, pslverr, ack, eoscan, req, wr, cond, smp, rack, rnak;
    logic [2:0]  res;
    logic [2:0]  seen = 0;
    int          fails = 0, comparisons = 0, cyc = 0;

    pdm_cmd_top #(.RND_MAX_PTS(16'd192)) DUT (.core_clk_i, .sys_rst_i, .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .system_protect_switch_i(prot), .other_cond_mon_i(omon), .cpu_ack_i(ack),
        .cpu_end_scan_i(eoscan), .cpu_cond_bit_i(cbit), .cpu_step_hit_i(step),
        .cpu_word_val_i(wval), .cpu_req_o(req), .cpu_wr_o(wr), .cpu_cond_o(cond),
        .cpu_sample_o(smp), .rsp_ack_o(rack), .rsp_nak_o(rnak));
    pdm_cpu_model CPU (.clk_i(core_clk_i), .rst_i(sys_rst_i), .req_i(req), .ack_o(ack),
        .end_scan_o(eoscan));

    // Clock, request watch and hang limit
    always #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (req)
            seen <= {cond, wr, 1'b1};
        if (cyc == 60000) begin
            fails = fails + 1;
            complete_run;
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected refusal of a batch request
    function automatic logic bnak(logic pri, bd, wd, w, pr, logic [23:0] h,
                                  logic [15:0] n, logic [23:0] mx);
        logic [15:0] lim;
        logic [27:0] last;
        lim = pri ? (wd ? 16'd480 : 16'd3952) : wd ? (bd ? (w ? 16'd10 : 16'd32) : 16'd64)
            : (w ? 16'd160 : 16'd256);
        last = 28'(h) + (wd && bd ? 28'(n) << 4 : 28'(n)) - 28'h1;
        return n == 0 || n > lim || (!pri && bd && wd && h[3:0] != 0) || last > 28'(mx)
            || (w && pri && pr);
    endfunction

    task automatic complete_run;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; read data taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        pen <= 1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask

    task automatic start(input logic [3:0] ctl, input logic [31:0] c, input logic [23:0] h,
                         input logic [15:0] n, input logic [31:0] rc, input logic [23:0] mx);
        seen <= 0;
        apb(1, ADDR_CMD, c);
        apb(1, ADDR_HEAD, {8'h0, h});
        apb(1, ADDR_COUNT, {16'h0, n});
        apb(1, ADDR_RCOUNT, rc);
        apb(1, ADDR_MAXDEV, {8'h0, mx});
        apb(1, ADDR_CTRL, {28'h0, ctl | 4'h1});
    endtask

    // Answer code: bit0 ack with sample, bit1 nak, bit2 CPU touched on nak or no sample
    task automatic await(input int lim);
        res = 3'b000;
        for (int i = 0; i < lim && res == 3'b000; i++) begin
            @(negedge core_clk_i);
            res = {rnak & seen[0] | rack & !smp, rnak, rack};
        end
        @(posedge core_clk_i);
    endtask

    task automatic run(input logic [3:0] ctl, input logic [31:0] c, input logic [31:0] rc,
                       input logic [15:0] n, input logic nak);
        start(ctl, c, 24'h0, n, rc, 24'h1fff);
        await(400);
        cmp(32'(res), nak ? 32'h2 : 32'h1, "answer");
    endtask

    task automatic bat(input logic pri, bd, wd, w, pr, input logic [23:0] h,
                       input logic [15:0] n, input logic [23:0] mx);
        logic e;
        e = bnak(pri, bd, wd, w, pr, h, n, mx);
        prot <= pr;
        start({bd, pri, 2'b00}, {15'h0, wd, w ? 16'h1401 : 16'h0401}, h, n, 32'h0, mx);
        await(400);
        cmp(32'(res), e ? 32'h2 : 32'h1, "batch");
        cmp(32'(seen[2:1]), 32'(w & !e), "write flag");
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk_i);
        sys_rst_i <= 0;
        apb(0, ADDR_STATUS, 0);
        cmp(rd, REG_RST, "status reset");
        apb(0, 8'h24, 0);
        cmp({rd[30:0], err}, 32'h1, "unmapped");
        bat(0, 1, 0, 0, 0, 0, 256, 8191);
        bat(0, 1, 0, 0, 0, 0, 257, 8191);
        apb(0, ADDR_STATUS, 0);
        cmp({rd[7:4], rd[2], rd[0]}, {CAUSE_COUNT, 2'b10}, "status nak");
        apb(1, ADDR_STATUS, 32'h6);
        apb(0, ADDR_STATUS, 0);
        cmp(rd[2:1], 0, "status clear");
        bat(1, 1, 0, 0, 0, 0, 3952, 16383);
        bat(1, 1, 0, 0, 0, 0, 3953, 16383);
        bat(0, 1, 1, 0, 0, 16, 32, 8191);
        bat(0, 1, 1, 0, 0, 16, 33, 8191);
        bat(0, 1, 1, 0, 0, 8, 2, 8191);
        bat(0, 0, 1, 0, 0, 0, 64, 8191);
        bat(0, 0, 1, 0, 0, 0, 65, 8191);
        bat(0, 1, 0, 1, 0, 0, 160, 8191);
        bat(0, 1, 0, 1, 0, 0, 161, 8191);
        bat(0, 1, 1, 1, 0, 0, 10, 8191);
        bat(0, 1, 1, 1, 0, 0, 11, 8191);
        bat(1, 1, 1, 1, 0, 0, 481, 8191);
        bat(1, 1, 1, 0, 0, 100, 2, 131);
        bat(1, 1, 1, 0, 0, 100, 2, 130);
        bat(1, 1, 0, 1, 1, 0, 5, 8191);
        bat(0, 1, 0, 1, 1, 0, 5, 8191);
        run(4'h0, 32'h0402, 0, 1, 1);
        repeat (30) begin
            r = xs();
            bat(r[0], r[1] ? r[3] : 1'b1, r[1], r[2], r[20], {14'h0, r[29:20]}, {7'h0, r[16:8]},
                {11'h0, r[31:19]});
        end
        run(4'h0, 32'h0403, 32'h000100bf, 0, 0);
        run(4'h0, 32'h0403, 32'h000100c0, 0, 1);
        run(4'h2, 32'h0403, 32'h30304330, 0, 0);
        run(4'h2, 32'h0403, 32'h30304331, 0, 1);
        run(4'h0, 32'h0403, 32'h0, 0, 1);
        run(4'h0, 32'h00010403, 32'h5, 0, 1);
        omon <= 1;
        run(4'h0, 32'h0403, 32'h5, 0, 1);
        run(4'h0, 32'h0802, 32'h5, 0, 1);
        omon <= 0;
        apb(1, ADDR_COND, 32'hf);
        apb(1, ADDR_CMPV, 32'h00ff00a5);
        r = xs();
        {cbit, step, wval} <= {2'b11, r[15:8], 8'h5a};
        start(4'h0, 32'h00400403, 24'h0, 16'h0, 32'h5, 24'h1fff);
        await(200);
        cmp(32'(res), 0, "word held");
        {cbit, wval} <= {1'b0, r[15:8], 8'ha5};
        await(200);
        cmp(32'(res), 0, "bit held");
        {cbit, step} <= 2'b10;
        await(200);
        cmp(32'(res), 0, "step held");
        step <= 1;
        await(200);
        cmp(32'(res), 1, "all met");
        cmp(32'(seen[2:1]), 32'h2, "cond flag");
        complete_run;
    end
endmodule
